/* File: logic/mem_space_pkg.sv */
// Constants, commands and carriers of the memory-space and stack block.
// Assumes a single core clock and a synchronous active-high reset.
package mem_space_pkg;

    // ----------------------------------------------------------------
    // Program memory and instruction pointer
    // ----------------------------------------------------------------
    localparam logic [12:0] IP_RESET = 13'h0000;
    localparam logic [12:0] SMALL_LAST_WORD = 13'h0FFF;
    localparam logic [12:0] LARGE_LAST_WORD_PRINTED = 13'h0EFF;
    localparam int LARGE_WORDS = 7936;
    localparam logic [12:0] CALL_DIRECT_MASK = 13'h07FF;

    // ----------------------------------------------------------------
    // Stack
    // ----------------------------------------------------------------
    localparam logic [3:0] SP_RESET = 4'h7;
    localparam logic [3:0] SMALL_HANG_SP = 4'h6;
    localparam logic [3:0] SP_TOP = 4'h7;
    localparam int IRQ_SAVE_DEPTH = 3;

    // ----------------------------------------------------------------
    // Data memory map
    // ----------------------------------------------------------------
    localparam logic [6:0] CPU_CONTROL_AREA_FIRST = 7'h74;
    localparam logic [6:0] PORT_FIRST = 7'h70;
    localparam logic [6:0] PORT_LAST_BANK0 = 7'h73;
    localparam logic [6:0] PORT_LAST_BANK1 = 7'h72;
    localparam logic [6:0] AUX_LAST = 7'h73;
    localparam logic [6:0] DBF_FIRST = 7'h0C;
    localparam logic [15:0] DBF_RESET = 16'h0320;
    localparam logic [1:0] BANK_COUNT = 2'h3;

    // System register nibble indices (address minus CPU_CONTROL_AREA_FIRST).
    localparam logic [3:0] IDX_AR3 = 4'h0;
    localparam logic [3:0] IDX_AR0 = 4'h3;
    localparam logic [3:0] IDX_BANK = 4'h5;
    localparam logic [3:0] IDX_RPH = 4'h9;
    localparam logic [3:0] IDX_RPL = 4'hA;
    localparam logic [3:0] IDX_PSW = 4'hB;

    // ----------------------------------------------------------------
    // Peripheral addresses
    // ----------------------------------------------------------------
    localparam logic [6:0] PERIPH_SERIAL = 7'h01;
    localparam logic [6:0] PERIPH_TIMER8 = 7'h02;
    localparam logic [6:0] PERIPH_TABLE_PTR = 7'h40;

    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_CALL = 4'h1,
        CMD_CALL_IND = 4'h3,
        CMD_TBL1 = 4'h2,
        CMD_TBL2 = 4'h6,
        CMD_PUSH = 4'h7,
        CMD_IRQ = 4'h5,
        CMD_RET = 4'h4,
        CMD_RETURN_SKIP_INSTR = 4'hC,
        CMD_POP = 4'hD,
        CMD_IRQ_RETURN_INSTR = 4'hF,
        CMD_JUMP = 4'hE
    } stack_cmd_t;

    typedef struct packed {
        logic we;
        logic gr_sel;
        logic [6:0] addr;
        logic [3:0] wdata;
    } dm_req_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [1:0] bank;
        logic [1:0] col;
        logic [3:0] wdata;
    } ext_req_t;

    typedef struct packed {
        logic put;
        logic get;
        logic [6:0] addr;
    } periph_req_t;

    typedef struct packed {
        logic serial_load;
        logic modulo_load;
        logic [7:0] data;
    } periph_out_t;

endpackage

/* File: logic/cpu_memory_space_stack.sv */
// Program counter, return and interrupt stacks, banked nibble data memory
// and transfer buffer of a 4-bit controller core.
// Assumes the instruction sequencer issues at most one stack command per
// cycle and that program memory answers in the same cycle as its address.
`timescale 1ns/1ps

module cpu_memory_space_stack
    import mem_space_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b0
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire stack_cmd_t stack_cmd,
    input wire logic [12:0] branch_target,
    input wire logic ip_advance,
    input wire logic [15:0] prog_rdata,
    input wire dm_req_t dm_req,
    input wire logic [3:0] ext_rdata,
    input wire periph_req_t periph_req,
    input wire logic [7:0] serial_shift_value,
    input wire logic [7:0] eight_bit_count_value,
    output logic [12:0] instruction_pointer,
    output logic [3:0] return_stack_pointer,
    output logic [3:0] dm_rdata,
    output ext_req_t ext_req,
    output periph_out_t periph_out,
    output logic [15:0] transfer_buffer,
    output logic [3:0] prog_status_word,
    output logic hang_up_out,
    output logic hang_up_oe_n
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [12:0] ip;
        logic [3:0] sp;
        logic [7:0][12:0] astk;
        logic [IRQ_SAVE_DEPTH-1:0][6:0] irq_save_stack;
        logic [11:0][3:0] sys;
        logic [15:0] dbf;
        logic wrapped;
        logic hang_oe_n;
        logic hang_level;
        logic [3:0] rdata;
        ext_req_t ext;
        periph_out_t pout;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // General-purpose nibbles of all banks; the regions that are mapped
    // elsewhere are simply never written here.
    logic [3:0] gp_ram [0:383];
    logic ram_we;
    logic [8:0] ram_idx;
    logic [3:0] ram_wdata;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [12:0] ip_mask(input logic [12:0] v);
        if (LARGE_VARIANT)
        begin
            ip_mask = v;
        end
        else
        begin
            ip_mask = v & SMALL_LAST_WORD;
        end
    endfunction

    function automatic logic [12:0] ip_step(input logic [12:0] v);
        logic [12:0] inc;
        inc = v + 13'h0001;
        if (LARGE_VARIANT && (32'(inc) >= LARGE_WORDS))
        begin
            ip_step = IP_RESET;
        end
        else
        begin
            ip_step = ip_mask(inc);
        end
    endfunction

    function automatic logic [3:0] sp_wrap(input logic [3:0] v);
        sp_wrap = {1'b0, v[2:0]};
    endfunction

    logic [15:0] ar_value;
    logic [1:0] bank_sel;
    logic [4:0] row_ptr;
    logic [12:0] ret_addr;
    logic [12:0] top_entry;
    logic [1:0] acc_bank;
    logic [6:0] acc_addr;
    logic bank_ok;

    always_comb
    begin
        ar_value = {state_reg.sys[IDX_AR3], state_reg.sys[IDX_AR3 + 4'h1],
                    state_reg.sys[IDX_AR0 - 4'h1], state_reg.sys[IDX_AR0]};
        bank_sel = state_reg.sys[IDX_BANK][1:0];
        row_ptr = {state_reg.sys[IDX_RPH], state_reg.sys[IDX_RPL][3]};
        ret_addr = ip_step(state_reg.ip);
        top_entry = state_reg.astk[state_reg.sp[2:0]];
        // Work register row: bank and row both come from the row pointer.
        if (dm_req.gr_sel)
        begin
            acc_bank = row_ptr[4:3];
            acc_addr = {row_ptr[2:0], dm_req.addr[3:0]};
        end
        else
        begin
            acc_bank = bank_sel;
            acc_addr = dm_req.addr;
        end
        bank_ok = (acc_bank < BANK_COUNT);
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [3:0] sp_dn;
        logic [3:0] sp_up;
        logic is_port;
        sp_dn = sp_wrap(state_reg.sp - 4'h1);
        sp_up = sp_wrap(state_reg.sp + 4'h1);
        state_next = state_reg;
        state_next.ext.req = 1'b0;
        state_next.pout.serial_load = 1'b0;
        state_next.pout.modulo_load = 1'b0;
        ram_we = 1'b0;
        ram_idx = {acc_bank[1:0], acc_addr};
        ram_wdata = dm_req.wdata;
        is_port = 1'b0;

        if (ip_advance)
        begin
            state_next.ip = ret_addr;
        end

        // Data memory port.
        if (acc_addr >= CPU_CONTROL_AREA_FIRST)
        begin
            // Shared by all banks, so no bank check here.
            state_next.rdata = state_reg.sys[4'(acc_addr - CPU_CONTROL_AREA_FIRST)];
            if (dm_req.we)
            begin
                state_next.sys[4'(acc_addr - CPU_CONTROL_AREA_FIRST)] = dm_req.wdata;
            end
        end
        else if (!bank_ok)
        begin
            state_next.rdata = 4'h0;
        end
        else if (acc_bank == 2'h0 && acc_addr[6:2] == DBF_FIRST[6:2])
        begin
            state_next.rdata = state_reg.dbf[{acc_addr[1:0], 2'h0} +: 4];
            if (dm_req.we)
            begin
                state_next.dbf[{acc_addr[1:0], 2'h0} +: 4] = dm_req.wdata;
            end
        end
        else if (acc_addr >= PORT_FIRST)
        begin
            is_port = (acc_bank == 2'h0 && acc_addr <= PORT_LAST_BANK0)
                || (acc_bank == 2'h1 && acc_addr <= PORT_LAST_BANK1)
                || (acc_bank == 2'h2 && acc_addr <= AUX_LAST);
            // Port and auxiliary RAM data go out; bank one 73H is a hole.
            state_next.ext.req = is_port;
            state_next.ext.we = dm_req.we;
            state_next.ext.bank = acc_bank;
            state_next.ext.col = acc_addr[1:0];
            state_next.ext.wdata = dm_req.wdata;
            state_next.rdata = is_port ? ext_rdata : 4'h0;
        end
        else
        begin
            state_next.rdata = gp_ram[ram_idx];
            ram_we = dm_req.we;
        end

        // Peripheral exchange through the two or four low buffer nibbles.
        if (periph_req.put)
        begin
            state_next.pout.data = state_reg.dbf[7:0];
            if (periph_req.addr == PERIPH_SERIAL)
            begin
                state_next.pout.serial_load = 1'b1;
            end
            else if (periph_req.addr == PERIPH_TIMER8)
            begin
                state_next.pout.modulo_load = 1'b1;
            end
            else if (periph_req.addr == PERIPH_TABLE_PTR)
            begin
                state_next.sys[IDX_AR3] = state_reg.dbf[15:12];
                state_next.sys[IDX_AR3 + 4'h1] = state_reg.dbf[11:8];
                state_next.sys[IDX_AR0 - 4'h1] = state_reg.dbf[7:4];
                state_next.sys[IDX_AR0] = state_reg.dbf[3:0];
            end
            // Any other address raises no load strobe; only the data field is refreshed.
        end
        else if (periph_req.get)
        begin
            if (periph_req.addr == PERIPH_SERIAL)
            begin
                state_next.dbf[7:0] = serial_shift_value;
            end
            else if (periph_req.addr == PERIPH_TIMER8)
            begin
                state_next.dbf[7:0] = eight_bit_count_value;
            end
            else if (periph_req.addr == PERIPH_TABLE_PTR)
            begin
                state_next.dbf = {3'h0, ip_mask(ar_value[12:0])};
            end
            // Unused addresses leave the buffer as it was.
        end

        // Stack commands.
        case (stack_cmd)
            CMD_JUMP:
            begin
                state_next.ip = ip_mask(branch_target);
            end
            CMD_CALL:
            begin
                state_next.astk[sp_dn[2:0]] = ret_addr;
                state_next.sp = sp_dn;
                state_next.ip = branch_target & CALL_DIRECT_MASK;
            end
            CMD_CALL_IND:
            begin
                state_next.astk[sp_dn[2:0]] = ret_addr;
                state_next.sp = sp_dn;
                state_next.ip = ip_mask(ar_value[12:0]);
            end
            CMD_TBL1:
            begin
                state_next.astk[sp_dn[2:0]] = ret_addr;
                state_next.sp = sp_dn;
                state_next.ip = ip_mask(ar_value[12:0]);
            end
            CMD_TBL2:
            begin
                state_next.dbf = prog_rdata;
                state_next.ip = top_entry;
                state_next.sp = sp_up;
            end
            CMD_PUSH:
            begin
                state_next.astk[sp_dn[2:0]] = ip_mask(ar_value[12:0]);
                state_next.sp = sp_dn;
            end
            CMD_POP:
            begin
                state_next.sys[IDX_AR3] = {3'h0, top_entry[12]};
                state_next.sys[IDX_AR3 + 4'h1] = top_entry[11:8];
                state_next.sys[IDX_AR0 - 4'h1] = top_entry[7:4];
                state_next.sys[IDX_AR0] = top_entry[3:0];
                state_next.sp = sp_up;
            end
            CMD_IRQ:
            begin
                // The interrupted instruction is resumed, not skipped.
                state_next.astk[sp_dn[2:0]] = state_reg.ip;
                state_next.sp = sp_dn;
                state_next.ip = ip_mask(branch_target);
                state_next.irq_save_stack = {state_reg.irq_save_stack[1:0],
                    state_reg.sys[IDX_BANK][2:0],
                    state_reg.sys[IDX_PSW]};
            end
            CMD_RET:
            begin
                state_next.ip = top_entry;
                state_next.sp = sp_up;
            end
            CMD_RETURN_SKIP_INSTR:
            begin
                state_next.ip = ip_step(top_entry);
                state_next.sp = sp_up;
            end
            CMD_IRQ_RETURN_INSTR:
            begin
                state_next.ip = top_entry;
                state_next.sp = sp_up;
                state_next.sys[IDX_BANK] =
                    {1'b0, state_reg.irq_save_stack[0][6:4]};
                state_next.sys[IDX_PSW] = state_reg.irq_save_stack[0][3:0];
                state_next.irq_save_stack = {7'h00,
                    state_reg.irq_save_stack[2:1]};
            end
            default:
            begin
            end
        endcase

        // Overflow alarm.
        if (LARGE_VARIANT)
        begin
            // A rise past seven wraps the pointer; hold the alarm.
            if ((stack_cmd == CMD_RET || stack_cmd == CMD_RETURN_SKIP_INSTR
                 || stack_cmd == CMD_TBL2 || stack_cmd == CMD_POP
                 || stack_cmd == CMD_IRQ_RETURN_INSTR) && state_reg.sp == SP_TOP)
            begin
                state_next.wrapped = 1'b1;
            end
            state_next.hang_oe_n = !state_next.wrapped;
        end
        else
        begin
            state_next.hang_oe_n = !(state_next.sp >= SMALL_HANG_SP);
        end
        state_next.hang_level = 1'b0;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_reg <= '0;
            state_reg.ip <= IP_RESET;
            state_reg.sp <= SP_RESET;
            state_reg.dbf <= DBF_RESET;
            state_reg.hang_oe_n <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Plain memory; contents are undefined after reset.
    always_ff @(posedge core_clk)
    begin
        if (ram_we && !sys_rst)
        begin
            gp_ram[ram_idx] <= ram_wdata;
        end
    end

    assign instruction_pointer = state_reg.ip;
    assign return_stack_pointer = state_reg.sp;
    assign dm_rdata = state_reg.rdata;
    assign ext_req = state_reg.ext;
    assign periph_out = state_reg.pout;
    assign transfer_buffer = state_reg.dbf;
    assign prog_status_word = state_reg.sys[IDX_PSW];
    assign hang_up_out = state_reg.hang_level;
    assign hang_up_oe_n = state_reg.hang_oe_n;

endmodule

/* File: test/mem_space_checker.sv */
// Checker for the memory-space and stack block, bound to its top ports.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps

module mem_space_checker
    import mem_space_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b0
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire stack_cmd_t stack_cmd,
    input wire logic [12:0] branch_target,
    input wire logic ip_advance,
    input wire logic [15:0] prog_rdata,
    input wire periph_req_t periph_req,
    input wire logic [12:0] instruction_pointer,
    input wire logic [3:0] return_stack_pointer,
    input wire logic [15:0] transfer_buffer,
    input wire periph_out_t periph_out,
    input wire logic hang_up_out,
    input wire logic hang_up_oe_n
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_reset;
        $fell(sys_rst) |-> instruction_pointer == 13'h0000 &&
            return_stack_pointer == 4'h7 && transfer_buffer == 16'h0320;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset values wrong");

    property p_sp_top;
        return_stack_pointer[3] == 1'b0;
    endproperty
    a_sp_top: assert property (p_sp_top)
        else $error("pointer top bit set");

    property p_call;
        stack_cmd == CMD_CALL |=> return_stack_pointer[2:0] ==
            $past(return_stack_pointer[2:0]) - 3'h1 &&
            instruction_pointer == ($past(branch_target) & CALL_DIRECT_MASK);
    endproperty
    a_call: assert property (p_call)
        else $error("direct call wrong");

    property p_down;
        stack_cmd inside {CMD_CALL_IND, CMD_TBL1, CMD_PUSH, CMD_IRQ} |=>
            return_stack_pointer[2:0] == $past(return_stack_pointer[2:0]) - 3'h1;
    endproperty
    a_down: assert property (p_down)
        else $error("pointer not lowered");

    property p_up;
        stack_cmd inside {CMD_RET, CMD_RETURN_SKIP_INSTR, CMD_TBL2, CMD_POP, CMD_IRQ_RETURN_INSTR} |=>
            return_stack_pointer[2:0] == $past(return_stack_pointer[2:0]) + 3'h1;
    endproperty
    a_up: assert property (p_up)
        else $error("pointer not raised");

    property p_advance;
        stack_cmd == CMD_NONE && ip_advance |=> instruction_pointer[11:0] ==
            $past(instruction_pointer[11:0]) + 12'h001;
    endproperty
    a_advance: assert property (p_advance)
        else $error("pointer step wrong");

    property p_table;
        stack_cmd == CMD_TBL2 |=> transfer_buffer == $past(prog_rdata);
    endproperty
    a_table: assert property (p_table)
        else $error("table word not loaded");

    property p_serial;
        periph_req.put && periph_req.addr == 7'h01 |=> periph_out.serial_load
            && periph_out.data == $past(transfer_buffer[7:0]);
    endproperty
    a_serial: assert property (p_serial)
        else $error("serial put wrong");

    property p_modulo;
        periph_req.put && periph_req.addr == 7'h02 |=> periph_out.modulo_load
            && !periph_out.serial_load;
    endproperty
    a_modulo: assert property (p_modulo)
        else $error("modulo put wrong");

    property p_hang;
        !LARGE_VARIANT && return_stack_pointer == 4'h6 |-> !hang_up_oe_n &&
            hang_up_out == 1'b0;
    endproperty
    a_hang: assert property (p_hang)
        else $error("hang-up not driven");
endmodule

bind cpu_memory_space_stack mem_space_checker #(
    .LARGE_VARIANT(LARGE_VARIANT)
) chk_i (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .stack_cmd(stack_cmd),
    .branch_target(branch_target),
    .ip_advance(ip_advance),
    .prog_rdata(prog_rdata),
    .periph_req(periph_req),
    .instruction_pointer(instruction_pointer),
    .return_stack_pointer(return_stack_pointer),
    .transfer_buffer(transfer_buffer),
    .periph_out(periph_out),
    .hang_up_out(hang_up_out),
    .hang_up_oe_n(hang_up_oe_n)
);

/* File: test/seq_periph_model.sv */
// Program memory, port nibbles and peripheral values beside the block.
// Assumes the block samples these in the cycle of its own request.
`timescale 1ns/1ps

module seq_periph_model
    import mem_space_pkg::*;
(
    input wire logic [12:0] instruction_pointer,
    input wire dm_req_t dm_req,
    output logic [15:0] prog_rdata,
    output logic [3:0] ext_rdata,
    output logic [7:0] serial_shift_value,
    output logic [7:0] eight_bit_count_value
);
    // Words carry their own address, so a wrong fetch address shows.
    assign prog_rdata = {3'h5, instruction_pointer};
    assign ext_rdata = ~dm_req.addr[3:0];
    assign serial_shift_value = 8'h3C;
    assign eight_bit_count_value = 8'h9E;
endmodule

/* File: test/cpu_memory_space_stack_bench.sv */
// Self-checking bench for the memory-space and stack block.
// Assumes the small variant and the partner model in seq_periph_model.
`timescale 1ns/1ps

module cpu_memory_space_stack_bench
    import mem_space_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    stack_cmd_t stack_cmd = CMD_NONE;
    logic [12:0] branch_target = 13'h0000;
    logic ip_advance = 1'b0;
    dm_req_t dm_req = '0;
    periph_req_t periph_req = '0;
    logic [15:0] prog_rdata;
    logic [3:0] ext_rdata;
    logic [7:0] serial_shift_value;
    logic [7:0] eight_bit_count_value;
    logic [12:0] instruction_pointer;
    logic [3:0] return_stack_pointer;
    logic [3:0] dm_rdata;
    ext_req_t ext_req;
    periph_out_t periph_out;
    logic [15:0] transfer_buffer;
    logic [3:0] prog_status_word;
    logic hang_up_out;
    logic hang_up_oe_n;
    int fails = 0;
    int num_checks = 0;

    always #20 core_clk = ~core_clk;

    cpu_memory_space_stack dut (.*);
    seq_periph_model model_i (.*);

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Commands stand for one cycle; the caller idles with CMD_NONE.
    task automatic issue(input stack_cmd_t c, input logic [12:0] t);
        @(negedge core_clk);
        stack_cmd = c;
        branch_target = t;
    endtask

    task automatic dm(input logic w, input logic [6:0] a, input logic [3:0] d);
        @(negedge core_clk);
        dm_req = '{we: w, gr_sel: 1'b0, addr: a, wdata: d};
        @(negedge core_clk);
        dm_req = '0;
    endtask

    task automatic periph(input logic p, input logic g, input logic [6:0] a);
        @(negedge core_clk);
        periph_req = '{put: p, get: g, addr: a};
        @(negedge core_clk);
        periph_req = '0;
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        chk(16'(instruction_pointer), 16'h0000);
        chk(16'(return_stack_pointer), 16'h0007);
        chk(transfer_buffer, 16'h0320);
        chk(16'(hang_up_oe_n), 16'h0001);
        ip_advance = 1'b1;
        repeat (3) @(negedge core_clk);
        ip_advance = 1'b0;
        chk(16'(instruction_pointer), 16'h0003);
        issue(CMD_CALL, 13'h0923);
        issue(CMD_NONE, 13'h0000);
        chk(16'(instruction_pointer), 16'h0123);
        chk(16'(return_stack_pointer), 16'h0006);
        chk(16'(hang_up_oe_n), 16'h0000);
        chk(16'(hang_up_out), 16'h0000);
        issue(CMD_RET, 13'h0000);
        issue(CMD_NONE, 13'h0000);
        chk(16'(instruction_pointer), 16'h0004);
        for (int i = 0; i < 4; i++)
            dm(1'b1, 7'h74 + 7'(i), 4'(16'h0456 >> (12 - 4 * i)));
        issue(CMD_TBL1, 13'h0000);
        issue(CMD_TBL2, 13'h0000);
        issue(CMD_NONE, 13'h0000);
        chk(transfer_buffer, 16'hA456);
        chk(16'(instruction_pointer), 16'h0005);
        issue(CMD_PUSH, 13'h0000);
        issue(CMD_CALL_IND, 13'h0000);
        issue(CMD_NONE, 13'h0000);
        chk(16'(instruction_pointer), 16'h0456);
        chk(16'(return_stack_pointer), 16'h0005);
        issue(CMD_RETURN_SKIP_INSTR, 13'h0000);
        issue(CMD_NONE, 13'h0000);
        chk(16'(instruction_pointer), 16'h0007);
        issue(CMD_POP, 13'h0000);
        issue(CMD_JUMP, 13'h1ABC);
        issue(CMD_NONE, 13'h0000);
        chk(16'(return_stack_pointer), 16'h0007);
        chk(16'(instruction_pointer), 16'h0ABC);
        dm(1'b0, 7'h0C, 4'h0);
        chk(16'(dm_rdata), 16'h0006);
        dm(1'b1, 7'h20, 4'h3);
        dm(1'b0, 7'h71, 4'h0);
        chk(16'(dm_rdata), 16'h000E);
        chk(16'(ext_req), 16'h0210);
        dm(1'b1, 7'h7F, 4'h9);
        dm(1'b1, 7'h79, 4'h1);
        dm(1'b1, 7'h20, 4'hC);
        dm(1'b0, 7'h7F, 4'h0);
        chk(16'(dm_rdata), 16'h0009);
        dm(1'b0, 7'h73, 4'h0);
        chk(16'(dm_rdata), 16'h0000);
        chk(16'(ext_req.req), 16'h0000);
        dm(1'b1, 7'h79, 4'h2);
        dm(1'b0, 7'h73, 4'h0);
        chk(16'(dm_rdata), 16'h000C);
        chk(16'(ext_req), 16'h02B0);
        dm(1'b1, 7'h79, 4'h0);
        dm(1'b0, 7'h20, 4'h0);
        chk(16'(dm_rdata), 16'h0003);
        // Row pointer picks bank zero row 2 while the bank register says one.
        dm(1'b1, 7'h7D, 4'h1);
        dm(1'b1, 7'h79, 4'h1);
        @(negedge core_clk);
        dm_req = '{we: 1'b0, gr_sel: 1'b1, addr: 7'h00, wdata: 4'h0};
        @(negedge core_clk);
        dm_req = '0;
        chk(16'(dm_rdata), 16'h0003);
        dm(1'b1, 7'h79, 4'h0);
        // Four nested entries: the fourth pushes the first one out.
        for (int i = 1; i < 5; i++)
        begin
            dm(1'b1, 7'h7F, 4'(i));
            issue(CMD_IRQ, 13'h0010);
            issue(CMD_NONE, 13'h0000);
        end
        chk(16'(instruction_pointer), 16'h0010);
        dm(1'b1, 7'h7F, 4'hA);
        for (int i = 4; i > 1; i--)
        begin
            issue(CMD_IRQ_RETURN_INSTR, 13'h0000);
            issue(CMD_NONE, 13'h0000);
            chk(16'(prog_status_word), 16'(i));
        end
        periph(1'b1, 1'b0, 7'h01);
        chk(16'(periph_out), 16'h0256);
        periph(1'b0, 1'b1, 7'h01);
        chk(transfer_buffer, 16'hA43C);
        periph(1'b0, 1'b1, 7'h02);
        chk(transfer_buffer, 16'hA49E);
        periph(1'b0, 1'b1, 7'h05);
        chk(transfer_buffer, 16'hA49E);
        periph(1'b1, 1'b0, 7'h02);
        chk(16'(periph_out), 16'h019E);
        periph(1'b1, 1'b0, 7'h05);
        chk(16'(periph_out[9:8]), 16'h0000);
        // A reset in mid-run must bring back the same start values.
        @(negedge core_clk);
        sys_rst = 1'b1;
        @(negedge core_clk);
        sys_rst = 1'b0;
        chk(16'(instruction_pointer), 16'h0000);
        chk(16'(return_stack_pointer), 16'h0007);
        chk(transfer_buffer, 16'h0320);
        report_and_stop();
    end

    // A hang is cut short here and counts as a mismatch.
    initial
    begin
        repeat (5000) @(posedge core_clk);
        fails++;
        report_and_stop();
    end
endmodule
